// file: logic/rss_pkg.sv
// Package: constants and types for the receiver sample stream interface
package rss_pkg;
	localparam int          SEG_LEN      = 16;
	localparam int          LANES        = 4;
	localparam logic [3:0]  SEG_LAST     = 4'hf;
	localparam logic [13:0] FRAC_FULL    = 14'h1000;
	localparam int          FRAC_W       = 12;
	localparam int          CFG_W        = 32;
	localparam int          CFG_AW       = 4;
	localparam int          CFG_DW       = 28;
	localparam logic [3:0]  CA_CONF3     = 4'h2;
	localparam logic [3:0]  CA_STRM      = 4'h6;
	localparam logic [3:0]  CA_CLK       = 4'h7;
	localparam logic [27:0] CONF3_RST    = 28'heafe1dc;
	localparam logic [27:0] STRM_RST     = 28'h8000000;
	localparam logic [27:0] CLK_RST      = 28'h10061b2;
	localparam int          CLK_L_LSB    = 16;
	localparam int          CLK_M_LSB    = 4;
	localparam int          LANE_LSB     = 4;
	localparam int          STRM_EN_BIT  = 27;
	localparam int          FRM_W        = 12;
	localparam logic [7:0]  A_CTRL       = 8'h00;
	localparam logic [7:0]  A_STRM       = 8'h04;
	localparam logic [7:0]  A_CLK        = 8'h08;
	localparam logic [7:0]  A_CONF3      = 8'h0c;
	localparam logic [7:0]  A_STAT       = 8'h10;
	localparam logic [31:0] CTRL_RST     = 32'h00400002;
	localparam int          DIV_W        = 8;
	localparam int          CTRL_PER_LSB = 8;
	localparam int          PER_W        = 15;
	localparam logic [7:0]  SER_DIV_MIN  = 8'h02;
	localparam logic [14:0] MARK_MIN     = 15'h0080;
	localparam logic [14:0] MARK_MAX     = 15'h4000;
	localparam int          ST_OVR_BIT   = 4;
	localparam int          PRE_ST_W     = 3;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} rss_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} rss_apb_rsp_t;

	typedef struct packed {
		logic [LANES-1:0][SEG_LEN-1:0] lane;
	} rss_slice_t;

	typedef struct packed {
		logic data;
		logic slice_start;
		logic sclk;
	} rss_stream_t;

	typedef enum logic [1:0] {
		LANE_B0  = 2'h0,
		LANE_B01 = 2'h1,
		LANE_B02 = 2'h2,
		LANE_ALL = 2'h3
	} rss_lane_t;

	typedef enum logic [1:0] {
		S_IDLE  = 2'b01,
		S_SHIFT = 2'b10
	} rss_state_t;
endpackage : rss_pkg

// file: logic/rss_buf2.sv
// Two-entry slice buffer with valid/ready on both sides
`timescale 1ns/10ps
module rss_buf2 (
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	// Fill side
	input  wire logic                in_valid_i,
	output logic                     in_ready_o,
	input  wire rss_pkg::rss_slice_t in_data_i,
	// Drain side
	output logic                     out_valid_o,
	input  wire logic                out_ready_i,
	output rss_pkg::rss_slice_t      out_data_o,
	output logic [1:0]               level_o
);
	import rss_pkg::*;

	rss_slice_t mem_q [2];
	rss_slice_t mem_d [2];
	logic       wp_q, wp_d, rp_q, rp_d;
	logic [1:0] cnt_q, cnt_d;
	logic       push, pop;

	assign in_ready_o  = (cnt_q != 2'h2);
	assign out_valid_o = (cnt_q != 2'h0);
	assign out_data_o  = mem_q[rp_q];
	assign level_o     = cnt_q;

	always_comb begin
		push  = in_valid_i && in_ready_o;
		pop   = out_valid_o && out_ready_i;
		mem_d = mem_q;
		wp_d  = wp_q;
		rp_d  = rp_q;
		cnt_d = cnt_q;
		if (push) begin
			mem_d[wp_q] = in_data_i;
			wp_d        = ~wp_q;
		end
		if (pop) begin
			rp_d = ~rp_q;
		end
		if (push && !pop) begin
			cnt_d = cnt_q + 2'h1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 2'h1;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			mem_q[0] <= '0;
			mem_q[1] <= '0;
			wp_q     <= 1'b0;
			rp_q     <= 1'b0;
			cnt_q    <= 2'h0;
		end else begin
			mem_q <= mem_d;
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
		end
	end
endmodule : rss_buf2

// file: logic/rss_top.sv
// Sample stream interface: clock divider, capture, serializer, config port
//
// The register offsets and the APB slave port were decided locally.
`timescale 1ns/10ps
//
// Behaviour
// - Fractional divider alternates neighbouring integer ratios
// - Ratio is L over 4096 minus M plus L
// - Four sample bits, I on 0-1, Q 2-3
// - Sign/magnitude: I sign, I mag, Q sign, Q mag
// - Serialize 16-bit segments, lanes 0,1,2,3
// - Lane select: b0, b0+b1, b0+b2, all
// - Two lanes alternate 16 bits each, once per slice
// - Serial rate at least lanes times converter; the code does not enforce this, a slower rate only sets overrun
// - Four 16-bit holding registers on converter clock
// - Every 16 converter periods holding moves to shifters; if the previous slice still waits, the code drops the new slice and sets overrun
// - Zeros follow valid data until next slice
// - Marker flags start of each slice
// - Periodic time marker, 128 to 16384 cycles
// - Preset pin high ignores config, picks state
// - Power-on reset loads default register values
// - 32-bit word, MSB first, while select low
// - Code 0110 frames, code 0111 divider counts
module rss_top (
	// Clock and reset
	input  wire logic                  REF_CLK_I,
	input  wire logic                  RST_I,
	// Register bus
	input  wire rss_pkg::rss_apb_req_t APB_REQ_I,
	output rss_pkg::rss_apb_rsp_t      APB_RSP_O,
	// Converter
	input  wire logic [3:0]            SAMPLE_I,
	output logic                       CONV_CLK_O,
	// Configuration pins
	input  wire logic                  CFG_SCLK_I,
	input  wire logic                  CFG_DATA_I,
	input  wire logic                  CFG_CS_N_I,
	input  wire logic                  PRESET_SELECT_PIN_I,
	output logic [2:0]                 PRESET_STATE_O,
	// Stream
	output rss_pkg::rss_stream_t       STREAM_O,
	output logic                       TIME_MARK_O
);
	import rss_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and shared decode
	logic [7:0]       sy1_q, sy2_q;
	logic             data_s, sclk_s, cs_s, pre;
	logic             sclk_p_q, cs_p_q, sclk_rise, cs_rise;
	logic             apb_setup, apb_wr;
	logic [27:0]      strm_q, strm_d, clkr_q, clkr_d, conf3_q, conf3_d;
	logic [31:0]      ctrl_q, ctrl_d;
	logic [31:0]      cfg_sh_q, cfg_sh_d;
	logic [2:0]       pst_q;
	logic             strm_wr, clk_wr, ovr_clr;
	logic [11:0]      l_cnt, m_cnt;
	logic [13:0]      den, sum, acc_q, acc_d;
	logic [14:0]      per;
	logic [7:0]       div;

	assign data_s    = sy2_q[5];
	assign sclk_s    = sy2_q[4];
	assign cs_s      = sy2_q[6];
	assign pre       = sy2_q[7];
	assign sclk_rise = sclk_s && !sclk_p_q;
	assign cs_rise   = cs_s && !cs_p_q;
	assign apb_setup = APB_REQ_I.psel && !APB_REQ_I.penable;
	assign apb_wr    = APB_REQ_I.psel && APB_REQ_I.penable && APB_REQ_I.pwrite;
	assign l_cnt     = clkr_q[CLK_L_LSB +: FRAC_W];
	assign m_cnt     = clkr_q[CLK_M_LSB +: FRAC_W];
	assign den       = FRAC_FULL - {2'h0, m_cnt} + {2'h0, l_cnt};
	assign sum       = acc_q + {2'h0, l_cnt};
	assign per       = (ctrl_q[CTRL_PER_LSB +: PER_W] < MARK_MIN) ? MARK_MIN :
	                   (ctrl_q[CTRL_PER_LSB +: PER_W] > MARK_MAX) ? MARK_MAX :
	                   ctrl_q[CTRL_PER_LSB +: PER_W];
	assign div       = (ctrl_q[DIV_W-1:0] < SER_DIV_MIN) ? SER_DIV_MIN : ctrl_q[DIV_W-1:0];

	////////////////////////////////////////////////////////////////////////
	// Divider, capture and time marker
	logic             conv_q, conv_d, mark_q, mark_d, pv_q, pv_d, ovr_q, ovr_d;
	logic [3:0]       scnt_q, scnt_d;
	logic [14:0]      mcnt_q, mcnt_d;
	logic [LANES-1:0][SEG_LEN-1:0] hold_q, hold_d, hold_sh;
	rss_slice_t       pend_q, pend_d, buf_od;
	logic             buf_in_rdy, buf_ov, load;
	logic [1:0]       buf_lvl;

	// lane i takes sample bit i
	// 0 I sign, 1 I mag, 2 Q sign, 3 Q mag
	for (genvar g = 0; g < LANES; g++) begin : g_lane
		assign hold_sh[g] = {hold_q[g][SEG_LEN-2:0], sy2_q[g]};
	end

	always_comb begin
		acc_d  = acc_q;
		conv_d = 1'b0;
		hold_d = hold_q;
		scnt_d = scnt_q;
		pend_d = pend_q;
		pv_d   = pv_q;
		ovr_d  = ovr_q && !ovr_clr;
		mcnt_d = mcnt_q;
		mark_d = 1'b0;
		// accumulate lead count, emit on overflow
		if (clk_wr) begin
			acc_d = 14'h0;
		end else if (sum >= den) begin
			acc_d  = sum - den;
			conv_d = 1'b1;
		end else begin
			acc_d = sum;
		end
		if (pv_q && buf_in_rdy) begin
			pv_d = 1'b0;
		end
		if (conv_q) begin
			hold_d = hold_sh;
			scnt_d = scnt_q + 4'h1;
			if (scnt_q == SEG_LAST) begin
				if (pv_d) begin
					ovr_d = 1'b1;
				end else begin
					pend_d.lane = hold_sh;
					pv_d        = 1'b1;
				end
			end
			if (mcnt_q >= per - 15'h1) begin
				mcnt_d = 15'h0;
				mark_d = 1'b1;
			end else begin
				mcnt_d = mcnt_q + 15'h1;
			end
		end
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			sy1_q  <= 8'h40;
			sy2_q  <= 8'h40;
			acc_q  <= 14'h0;
			conv_q <= 1'b0;
			hold_q <= '0;
			scnt_q <= 4'h0;
			pend_q <= '0;
			pv_q   <= 1'b0;
			ovr_q  <= 1'b0;
			mcnt_q <= 15'h0;
			mark_q <= 1'b0;
		end else begin
			sy1_q  <= {PRESET_SELECT_PIN_I, CFG_CS_N_I, CFG_DATA_I, CFG_SCLK_I, SAMPLE_I};
			sy2_q  <= sy1_q;
			acc_q  <= acc_d;
			conv_q <= conv_d;
			hold_q <= hold_d;
			scnt_q <= scnt_d;
			pend_q <= pend_d;
			pv_q   <= pv_d;
			ovr_q  <= ovr_d;
			mcnt_q <= mcnt_d;
			mark_q <= mark_d;
		end
	end

	rss_buf2 u_buf (
		.clk_i       (REF_CLK_I),
		.rst_i       (RST_I),
		.in_valid_i  (pv_q),
		.in_ready_o  (buf_in_rdy),
		.in_data_i   (pend_q),
		.out_valid_o (buf_ov),
		.out_ready_i (load),
		.out_data_o  (buf_od),
		.level_o     (buf_lvl)
	);

	////////////////////////////////////////////////////////////////////////
	// Three-wire port and register writes
	logic [3:0]       cfg_a;
	logic [27:0]      cfg_dat;

	assign cfg_a   = cfg_sh_q[CFG_AW-1:0];
	assign cfg_dat = cfg_sh_q[CFG_W-1:CFG_AW];

	always_comb begin
		cfg_sh_d = cfg_sh_q;
		strm_d   = strm_q;
		clkr_d   = clkr_q;
		conf3_d  = conf3_q;
		ctrl_d   = ctrl_q;
		strm_wr  = 1'b0;
		clk_wr   = 1'b0;
		ovr_clr  = 1'b0;
		if (sclk_rise && !cs_s) begin
			cfg_sh_d = {cfg_sh_q[CFG_W-2:0], data_s};
		end
		if (apb_wr) begin
			if (APB_REQ_I.paddr == A_CTRL) begin
				ctrl_d = APB_REQ_I.pwdata;
			end else if (APB_REQ_I.paddr == A_STAT) begin
				ovr_clr = APB_REQ_I.pwdata[ST_OVR_BIT];
			end else if (!pre && APB_REQ_I.paddr == A_STRM) begin
				strm_d  = APB_REQ_I.pwdata[CFG_DW-1:0];
				strm_wr = 1'b1;
			end else if (!pre && APB_REQ_I.paddr == A_CLK) begin
				clkr_d = APB_REQ_I.pwdata[CFG_DW-1:0];
				clk_wr = 1'b1;
			end else if (!pre && APB_REQ_I.paddr == A_CONF3) begin
				conf3_d = APB_REQ_I.pwdata[CFG_DW-1:0];
			end
		end
		if (cs_rise && !pre) begin
			if (cfg_a == CA_STRM) begin
				strm_d  = cfg_dat;
				strm_wr = 1'b1;
			end else if (cfg_a == CA_CLK) begin
				clkr_d = cfg_dat;
				clk_wr = 1'b1;
			end else if (cfg_a == CA_CONF3) begin
				conf3_d = cfg_dat;
			end
		end
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			sclk_p_q <= 1'b0;
			cs_p_q   <= 1'b1;
			cfg_sh_q <= 32'h0;
			strm_q   <= STRM_RST;
			clkr_q   <= CLK_RST;
			conf3_q  <= CONF3_RST;
			ctrl_q   <= CTRL_RST;
			pst_q    <= 3'h0;
		end else begin
			sclk_p_q <= sclk_s;
			cs_p_q   <= cs_s;
			cfg_sh_q <= cfg_sh_d;
			strm_q   <= strm_d;
			clkr_q   <= clkr_d;
			conf3_q  <= conf3_d;
			ctrl_q   <= ctrl_d;
			pst_q    <= {sclk_s, data_s, cs_s};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serializer
	rss_state_t       st_q, st_d;
	rss_lane_t        lsel, sel_q, sel_d;
	rss_slice_t       slice_q, slice_d;
	logic [1:0]       cur_q, cur_d, nxt;
	logic [3:0]       bc_q, bc_d;
	logic [7:0]       sdiv_q, sdiv_d;
	logic [11:0]      sent_q, sent_d, frm_lim;
	logic             ser_en_q, ser_en_d, d_q, d_d, ss_q, ss_d, sck_q, run, last;

	assign frm_lim = strm_q[FRM_W-1:0];
	assign run     = strm_q[STRM_EN_BIT] && (frm_lim == 12'h0 || sent_q < frm_lim);
	assign lsel    = pre ? ((pst_q < 3'h2) ? LANE_B0 : LANE_B01) :
	                 rss_lane_t'(conf3_q[LANE_LSB +: 2]);
	assign nxt     = (sel_q == LANE_B02) ? 2'h2 : cur_q + 2'h1;
	assign last    = (sel_q == LANE_B0) || (sel_q != LANE_ALL && cur_q != 2'h0) || (cur_q == 2'h3);

	always_comb begin
		sdiv_d   = (sdiv_q >= div - 8'h1) ? 8'h0 : sdiv_q + 8'h1;
		ser_en_d = (sdiv_q >= div - 8'h1);
		st_d     = st_q;
		sel_d    = sel_q;
		slice_d  = slice_q;
		cur_d    = cur_q;
		bc_d     = bc_q;
		d_d      = d_q;
		ss_d     = 1'b0;
		sent_d   = strm_wr ? 12'h0 : sent_q;
		load     = 1'b0;
		if (ser_en_q) begin
			case (st_q)
				S_IDLE: begin
					d_d = 1'b0;
					if (buf_ov && run) begin
						load    = 1'b1;
						slice_d = buf_od;
						sel_d   = lsel;
						cur_d   = 2'h0;
						bc_d    = SEG_LAST;
						d_d     = buf_od.lane[0][SEG_LAST];
						ss_d    = 1'b1;
						st_d    = S_SHIFT;
						sent_d  = strm_wr ? 12'h0 : sent_q + 12'h1;
					end
				end
				S_SHIFT: begin
					if (bc_q != 4'h0) begin
						bc_d = bc_q - 4'h1;
						d_d  = slice_q.lane[cur_q][bc_q - 4'h1];
					end else if (!last) begin
						cur_d = nxt;
						bc_d  = SEG_LAST;
						d_d   = slice_q.lane[nxt][SEG_LAST];
						ss_d  = 1'b1;
					end else begin
						d_d  = 1'b0;
						st_d = S_IDLE;
					end
				end
				default: begin
					st_d = S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			st_q     <= S_IDLE;
			sel_q    <= LANE_B0;
			slice_q  <= '0;
			cur_q    <= 2'h0;
			bc_q     <= 4'h0;
			sdiv_q   <= 8'h0;
			ser_en_q <= 1'b0;
			sent_q   <= 12'h0;
			d_q      <= 1'b0;
			ss_q     <= 1'b0;
			sck_q    <= 1'b0;
		end else begin
			st_q     <= st_d;
			sel_q    <= sel_d;
			slice_q  <= slice_d;
			cur_q    <= cur_d;
			bc_q     <= bc_d;
			sdiv_q   <= sdiv_d;
			ser_en_q <= ser_en_d;
			sent_q   <= sent_d;
			d_q      <= d_d;
			ss_q     <= ss_d;
			sck_q    <= ser_en_q;
		end
	end

	assign STREAM_O.data        = d_q;
	assign STREAM_O.slice_start = ss_q;
	assign STREAM_O.sclk        = sck_q;
	assign TIME_MARK_O          = mark_q;
	assign CONV_CLK_O           = conv_q;
	assign PRESET_STATE_O       = pst_q;

	////////////////////////////////////////////////////////////////////////
	// Register bus read side
	logic [31:0] rdata_q, rdata_d;
	logic        hit;

	always_comb begin
		rdata_d = rdata_q;
		hit     = 1'b1;
		if (APB_REQ_I.paddr == A_CTRL) begin
			if (apb_setup) rdata_d = ctrl_q;
		end else if (APB_REQ_I.paddr == A_STRM) begin
			if (apb_setup) rdata_d = {4'h0, strm_q};
		end else if (APB_REQ_I.paddr == A_CLK) begin
			if (apb_setup) rdata_d = {4'h0, clkr_q};
		end else if (APB_REQ_I.paddr == A_CONF3) begin
			if (apb_setup) rdata_d = {4'h0, conf3_q};
		end else if (APB_REQ_I.paddr == A_STAT) begin
			if (apb_setup) rdata_d = {22'h0, buf_lvl, cur_q, 1'b0, ovr_q, pre, pst_q};
		end else begin
			hit = 1'b0;
			if (apb_setup) rdata_d = 32'h0;
		end
	end

	always_ff @(posedge REF_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			rdata_q <= 32'h0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign APB_RSP_O.prdata  = rdata_q;
	assign APB_RSP_O.pready  = 1'b1;
	assign APB_RSP_O.pslverr = APB_REQ_I.psel && APB_REQ_I.penable && !hit;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge REF_CLK_I);
	endclocking
	default disable iff (RST_I);

	frac_range_a: assert property (acc_q < den)
		else $error("divider accumulator out of range");
	frac_pulse_a: assert property (!clk_wr && sum >= den |=> conv_q)
		else $error("divider pulse missing");
	cap_iq_a: assert property (conv_q |=> hold_q[0][0] == $past(sy2_q[0]) && hold_q[2][0] == $past(sy2_q[2]))
		else $error("sample bits not captured");
	cap_mag_a: assert property (conv_q |=> hold_q[3][0] == $past(sy2_q[3]))
		else $error("quadrature magnitude lost");
	seg_count_a: assert property (conv_q |=> scnt_q == $past(scnt_q) + 4'h1)
		else $error("segment count stalled");
	slice_hand_a: assert property (conv_q && scnt_q == SEG_LAST |=> pv_q)
		else $error("segment not handed on");
	overrun_a: assert property (conv_q && scnt_q == SEG_LAST && pv_q && !buf_in_rdy |=> ovr_q)
		else $error("overrun not flagged");
	lane_only0_a: assert property (st_q == S_SHIFT && sel_q == LANE_B0 |-> cur_q == 2'h0)
		else $error("extra lane streamed");
	lane_pair_a: assert property (st_q == S_SHIFT && sel_q == LANE_B02 |-> cur_q == 2'h0 || cur_q == 2'h2)
		else $error("wrong second lane");
	lane_order_a: assert property (ss_q && $past(st_q) == S_SHIFT && sel_q == LANE_ALL |-> cur_q == $past(cur_q) + 2'h1)
		else $error("lane order broken");
	zero_fill_a: assert property (ser_en_q && st_q == S_IDLE && !load |=> !d_q)
		else $error("idle stream not zero");
	slice_mark_a: assert property (ss_q |-> bc_q == SEG_LAST && $past(ser_en_q))
		else $error("marker off slice start");
	first_bit_a: assert property (ss_q |-> d_q == slice_q.lane[cur_q][SEG_LAST])
		else $error("first bit not earliest");
	mark_gap_a: assert property (mark_q |-> mcnt_q == 15'h0 && $past(conv_q))
		else $error("time marker misplaced");
	preset_hold_a: assert property (pre && cs_rise && !apb_wr |=> $stable(clkr_q) && $stable(strm_q))
		else $error("preset mode took config");
	cfg_shift_a: assert property (sclk_rise && !cs_s |=> cfg_sh_q[0] == $past(data_s))
		else $error("config bit not shifted");
	cfg_commit_a: assert property (cs_rise && !pre && cfg_a == CA_CLK |=> clkr_q == $past(cfg_dat))
		else $error("config word not written");
	cfg_strm_a: assert property (cs_rise && !pre && cfg_a == CA_STRM |=> strm_q == $past(cfg_dat) && sent_q == 12'h0)
		else $error("frame register not written");
endmodule : rss_top

// file: dv/rss_bb_model.sv
// Baseband partner: three-wire writer and stream receiver
`timescale 1ns/10ps
module rss_bb_model (
	// Clock and stream
	input  wire logic                 clk_i,
	input  wire rss_pkg::rss_stream_t stream_i,
	// Three-wire port
	output logic                      cfg_sclk_o,
	output logic                      cfg_data_o,
	output logic                      cfg_cs_n_o
);
	import rss_pkg::*;
	logic [15:0] cur_q;
	logic [15:0] seg_q [4];
	logic [15:0] done_q [4];
	int          bits_q;
	int          n_q;
	int          done_n_q;
	int          idle_bad_q;
	logic        gap_q = 1'b1;

	initial begin
		cfg_sclk_o = 1'b0;
		cfg_data_o = 1'b0;
		cfg_cs_n_o = 1'b1;
	end

	////////////////////////////////////////////////////////////////
	task automatic hold(input int n);
		repeat (n) @(posedge clk_i);
	endtask : hold

	task automatic pins(input logic [2:0] v);
		@(posedge clk_i);
		{cfg_sclk_o, cfg_data_o, cfg_cs_n_o} <= v;
	endtask : pins

	task automatic cfg_write(input logic [27:0] d, input logic [3:0] ad);
		logic [31:0] w;
		w = {d, ad};
		@(posedge clk_i);
		cfg_cs_n_o <= 1'b0;
		for (int i = 31; i >= 0; i--) begin
			hold(3);
			cfg_data_o <= w[i];
			hold(3);
			cfg_sclk_o <= 1'b1;
			hold(3);
			cfg_sclk_o <= 1'b0;
		end
		hold(3);
		cfg_cs_n_o <= 1'b1;
		cfg_data_o <= ~w[0];
		hold(8);
	endtask : cfg_write

	////////////////////////////////////////////////////////////////
	always @(posedge clk_i) begin
		if (stream_i.sclk) begin
			if (stream_i.slice_start) begin
				cur_q  <= {15'h0, stream_i.data};
				bits_q <= 1;
				gap_q  <= 1'b0;
				if (gap_q)
					n_q <= 0;
			end else if (bits_q > 0 && bits_q < 16) begin
				cur_q  <= {cur_q[14:0], stream_i.data};
				bits_q <= bits_q + 1;
				if (bits_q == 15 && n_q < 4) begin
					seg_q[n_q] <= {cur_q[14:0], stream_i.data};
					n_q        <= n_q + 1;
				end
			end else begin
				if (stream_i.data !== 1'b0)
					idle_bad_q <= idle_bad_q + 1;
				if (!gap_q) begin
					done_q   <= seg_q;
					done_n_q <= n_q;
				end
				gap_q  <= 1'b1;
				bits_q <= 0;
			end
		end
	end
endmodule : rss_bb_model

// file: dv/rss_top_tb.sv
// Testbench for the sample stream interface
`timescale 1ns/10ps
module rss_top_tb;
	import rss_pkg::*;
	logic         clk;
	logic         rst;
	rss_apb_req_t req;
	rss_apb_rsp_t rsp;
	logic [3:0]   smp;
	logic         conv;
	logic         sclk;
	logic         sdat;
	logic         cs_n;
	logic         preset;
	logic         mark;
	logic         watch;
	logic [2:0]   pstate;
	rss_stream_t  st;
	logic [31:0]  r;
	logic         e;
	int           errors;
	int           compares;
	int           cyc;
	int           conv_n;
	int           since;
	int           gap_n;
	int           gl;
	int           bad_gap;
	int           a;
	int           nl [4] = '{1, 2, 2, 4};
	int           ln [4][4] = '{'{0, 0, 0, 0}, '{0, 1, 0, 0}, '{0, 2, 0, 0}, '{0, 1, 2, 3}};
	logic [15:0]  kp [4] = '{16'hc3a5, 16'h0ff0, 16'h96e1, 16'h5a3c};

	rss_top dut (
		.REF_CLK_I          (clk),
		.RST_I              (rst),
		.APB_REQ_I          (req),
		.APB_RSP_O          (rsp),
		.SAMPLE_I           (smp),
		.CONV_CLK_O         (conv),
		.CFG_SCLK_I         (sclk),
		.CFG_DATA_I         (sdat),
		.CFG_CS_N_I         (cs_n),
		.PRESET_SELECT_PIN_I(preset),
		.PRESET_STATE_O     (pstate),
		.STREAM_O           (st),
		.TIME_MARK_O        (mark)
	);

	rss_bb_model bb (
		.clk_i     (clk),
		.stream_i  (st),
		.cfg_sclk_o(sclk),
		.cfg_data_o(sdat),
		.cfg_cs_n_o(cs_n)
	);

	////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		if (errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: ad, pwdata: d};
		@(posedge clk);
		req.penable <= 1'b1;
		do @(posedge clk); while (rsp.pready !== 1'b1);
		r = rsp.prdata;
		e = rsp.pslverr;
		req.psel    <= 1'b0;
		req.penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [7:0] ad, input logic [31:0] x);
		apb(1'b0, ad, 32'h0);
		chk(r, x);
	endtask : rd

	// Sample bits for converter pulse p: lane i ends as kp[i]
	function automatic logic [3:0] pat(input int p);
		logic [3:0] v;
		for (int i = 0; i < 4; i++)
			v[i] = kp[i][4'hf - p[3:0]];
		return v;
	endfunction : pat

	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk) begin
		cyc   <= cyc + 1;
		if (rst)
			smp <= pat(0);
		else if (conv)
			smp <= pat(conv_n + 1);
		since <= mark ? 0 : since + conv;
		if (mark)
			gap_n <= since + conv;
		if (conv) begin
			conv_n <= conv_n + 1;
			gl     <= 1;
			if (watch && (gl < 3 || gl > 4))
				bad_gap <= bad_gap + 1;
		end else
			gl <= gl + 1;
		if (cyc == 20000) begin
			errors++;
			tally_and_finish();
		end
	end

	////////////////////////////////////////////////////////////////
	initial begin
		rst    = 1'b1;
		req    = '0;
		preset = 1'b0;
		watch  = 1'b0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		rd(A_CTRL, CTRL_RST);
		rd(A_STRM, {4'h0, STRM_RST});
		rd(A_CLK, {4'h0, CLK_RST});
		rd(A_CONF3, {4'h0, CONF3_RST});
		rd(8'h14, 32'h0);
		chk({31'h0, e}, 32'h1);
		bb.cfg_write(28'h001ff10, CA_CLK);
		rd(A_CLK, 32'h0001ff10);
		bb.cfg_write({CONF3_RST[27:6], 2'h3, CONF3_RST[3:0]}, CA_CONF3);
		rd(A_CONF3, {4'h0, CONF3_RST[27:6], 2'h3, CONF3_RST[3:0]});
		bb.cfg_write(28'hc000000, CA_STRM);
		rd(A_STRM, 32'h0c000000);
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, A_CONF3, {4'h0, CONF3_RST[27:6], m[1:0], CONF3_RST[3:0]});
			bb.hold(1100);
			chk(bb.done_n_q, nl[m]);
			for (int k = 0; k < nl[m]; k++)
				chk(bb.done_q[k], {16'h0, kp[ln[m][k]]});
		end
		apb(1'b1, A_CTRL, {9'h0, 15'h0010, 8'h02});
		apb(1'b1, A_CLK, 32'h0002ffb0);
		bb.hold(20);
		watch <= 1'b1;
		a = conv_n;
		bb.hold(700);
		watch <= 1'b0;
		chk({31'h0, (conv_n - a) inside {[199:201]}}, 32'h1);
		chk(bad_gap, 0);
		bb.hold(1000);
		chk(gap_n, 128);
		apb(1'b0, A_STAT, 32'h0);
		chk({31'h0, r[ST_OVR_BIT]}, 32'h1);
		apb(1'b1, A_CLK, 32'h0001ff10);
		bb.hold(1500);
		apb(1'b1, A_STAT, 32'h10);
		apb(1'b0, A_STAT, 32'h0);
		chk({31'h0, r[ST_OVR_BIT]}, 32'h0);
		bb.pins(3'b101);
		preset <= 1'b1;
		bb.hold(6);
		chk({29'h0, pstate}, 32'h5);
		apb(1'b0, A_STAT, 32'h0);
		chk({28'h0, r[3:0]}, 32'hd);
		apb(1'b1, A_CLK, 32'h0);
		rd(A_CLK, 32'h0001ff10);
		bb.pins(3'b001);
		bb.cfg_write(28'h0, CA_CLK);
		rd(A_CLK, 32'h0001ff10);
		preset <= 1'b0;
		bb.hold(6);
		chk(bb.idle_bad_q, 0);
		tally_and_finish();
	end
endmodule : rss_top_tb
